// ==== src/ivp_vector_place.sv ====
// module: reset and interrupt vector address generation with table relocation
// Behaviour
// - any reset targets vector one, at zero unless the fuse is programmed
// - external requests 0-2 use 0x002/0x004/0x006
// - timer2 compare 0x008, overflow 0x00A
// - timer1 capture, compare A/B, overflow 0x00C-0x012
// - timer0 compare 0x014, overflow 0x016
// - serial, usart rx, empty, tx 0x018-0x01E
// - five more sources 0x020-0x028; 21 vectors
// - programmed fuse starts at boot reset address
// - select bit adds boot start to vectors
// - reset/table base chosen by fuse and select
// - fuse value 0 means programmed
// - slot fetched only for taken enabled interrupt
// - select change needs unlock then write within four
// - unlock blocks interrupts, global flag untouched
module ivp_vector_place (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic        i_boot_reset_fuse,
  input  wire logic [13:0] i_boot_addr,
  input  wire logic        i_ctl_wr,
  input  wire logic        i_wr_vector_table_select,
  input  wire logic        i_wr_vector_change_unlock,
  input  wire logic        i_instr_done,
  input  wire logic        i_global_irq_en,
  input  wire logic [19:0] i_irq_pending,
  input  wire logic [19:0] i_irq_enable,
  input  wire logic        i_irq_ready,
  output logic             o_reset_fetch,
  output logic [13:0]      o_fetch_addr,
  output logic             o_irq_take,
  output logic [4:0]       o_vec_num,
  output logic             o_vector_table_select,
  output logic             o_vector_change_unlock,
  output logic             o_irq_blocked
);

  // ==========================================================
  // address helpers
  function automatic logic [13:0] slot_addr(input logic [13:0] base, input logic [4:0] idx);
    slot_addr = base + 14'(idx) * ivp_pkg::SLOT_STRIDE;
  endfunction : slot_addr

  function automatic logic [13:0] table_base(input logic sel, input logic [13:0] boot);
    table_base = sel ? (boot + ivp_pkg::TABLE_BASE) : ivp_pkg::TABLE_BASE;
  endfunction : table_base

  function automatic logic [13:0] reset_target(input logic fuse, input logic [13:0] boot);
    reset_target = (fuse == ivp_pkg::FUSE_PROGRAMMED) ? boot : ivp_pkg::RESET_ADDR;
  endfunction : reset_target

  // ==========================================================
  // priority selection
  logic [19:0] req;
  logic        req_any;
  logic [4:0]  req_idx;
  assign req = i_irq_pending & i_irq_enable;

  ivp_prio_enc u_prio (
    .i_req (req),
    .o_any (req_any),
    .o_idx (req_idx)
  );

  // ==========================================================
  // control state: select bit and unlock window
  logic        sel_q, sel_d;
  logic        unl_q, unl_d;
  logic [2:0]  cnt_q, cnt_d;
  logic        unl_wr;
  logic        sel_wr;

  assign unl_wr = i_ctl_wr && i_wr_vector_change_unlock;
  assign sel_wr = i_ctl_wr && !i_wr_vector_change_unlock && unl_q;

  always_comb begin
    sel_d = sel_q;
    unl_d = unl_q;
    cnt_d = cnt_q;
    // unlock window counts down four enabled cycles
    if (unl_q) begin
      if (cnt_q == 3'h1) begin
        unl_d = 1'b0;
      end
      cnt_d = cnt_q - 3'h1;
    end
    if (unl_wr) begin
      unl_d = 1'b1;
      cnt_d = ivp_pkg::UNLOCK_CYCLES;
    end else if (sel_wr) begin
      sel_d = i_wr_vector_table_select;
      unl_d = 1'b0;
      cnt_d = 3'h0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sel_q <= ivp_pkg::SEL_RESET;
      unl_q <= ivp_pkg::UNLOCK_RESET;
      cnt_q <= 3'h0;
    end else if (i_ce) begin
      sel_q <= sel_d;
      unl_q <= unl_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // block state: interrupts held off around a select change
  logic        hold_q, hold_d;
  logic        blk_q, blk_d;
  logic        blocked;

  always_comb begin
    hold_d = 1'b0;
    if (sel_wr) begin
      hold_d = 1'b1;
    end
    // keep blocking until the following instruction completes
    if (hold_q && !i_instr_done) begin
      hold_d = 1'b1;
    end
    // the cycle of the unlock write is blocked already
    blocked = unl_wr || unl_q || hold_q;
    blk_d   = blocked || unl_d || hold_d;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      hold_q <= 1'b0;
      blk_q  <= 1'b0;
    end else if (i_ce) begin
      hold_q <= hold_d;
      blk_q  <= blk_d;
    end
  end

  // ==========================================================
  // fetch state: reset target and taken vector
  logic        boot_q, boot_d;
  logic        rfetch_q, rfetch_d;
  logic [13:0] addr_q, addr_d;
  logic        take_q, take_d;
  logic [4:0]  vnum_q, vnum_d;
  logic [13:0] tbase;
  logic        take_now;

  assign tbase    = table_base(sel_q, i_boot_addr);
  assign take_now = req_any && i_global_irq_en && i_irq_ready && !blocked;

  always_comb begin
    boot_d   = 1'b0;
    rfetch_d = 1'b0;
    take_d   = 1'b0;
    addr_d   = addr_q;
    vnum_d   = vnum_q;
    if (boot_q) begin
      // first enabled cycle after reset: issue the reset target
      rfetch_d = 1'b1;
      vnum_d   = ivp_pkg::VEC_NUM_RESET;
      addr_d   = reset_target(i_boot_reset_fuse, i_boot_addr);
    end else if (take_now) begin
      take_d = 1'b1;
      vnum_d = req_idx + ivp_pkg::VEC_NUM_FIRST;
      addr_d = slot_addr(tbase, req_idx);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      boot_q   <= 1'b1;
      rfetch_q <= 1'b0;
      addr_q   <= ivp_pkg::RESET_ADDR;
      take_q   <= 1'b0;
      vnum_q   <= 5'h00;
    end else if (i_ce) begin
      boot_q   <= boot_d;
      rfetch_q <= rfetch_d;
      addr_q   <= addr_d;
      take_q   <= take_d;
      vnum_q   <= vnum_d;
    end
  end

  // ==========================================================
  // outputs
  assign o_reset_fetch          = rfetch_q;
  assign o_fetch_addr           = addr_q;
  assign o_irq_take             = take_q;
  assign o_vec_num              = vnum_q;
  assign o_vector_table_select  = sel_q;
  assign o_vector_change_unlock = unl_q;
  assign o_irq_blocked          = blk_q;

endmodule : ivp_vector_place

// ==== src/ivp_pkg.sv ====
// package: vector numbers, addresses and timing counts for the vector placement block
package ivp_pkg;
  localparam int unsigned        SRC_COUNT      = 20;
  localparam int unsigned        VEC_COUNT      = 21;
  localparam int unsigned        ADDR_W         = 14;
  localparam int unsigned        VEC_NUM_W      = 5;
  localparam logic [13:0]        RESET_ADDR     = 14'h0000;
  localparam logic [13:0]        TABLE_BASE     = 14'h0002;
  localparam logic [13:0]        SLOT_STRIDE    = 14'h0002;
  localparam logic [13:0]        BOOT_ADDR_DFLT = 14'h3800;
  localparam logic               FUSE_PROGRAMMED = 1'b0;
  localparam logic               SEL_RESET      = 1'b0;
  localparam logic               UNLOCK_RESET   = 1'b0;
  localparam logic [2:0]         UNLOCK_CYCLES  = 3'h4;
  localparam logic [4:0]         VEC_NUM_RESET  = 5'h01;
  localparam logic [4:0]         VEC_NUM_FIRST  = 5'h02;
  // source bit positions, lowest bit has highest priority
  localparam int unsigned        SRC_EXT_IRQ_0  = 0;
  localparam int unsigned        SRC_SELF_PROGRAM_READY = 19;
endpackage : ivp_pkg

// ==== src/ivp_prio_enc.sv ====
// module: lowest-index priority encoder over the pending sources
module ivp_prio_enc (
  input  wire logic [19:0] i_req,
  output logic             o_any,
  output logic [4:0]       o_idx
);
  always_comb begin
    o_any = 1'b0;
    o_idx = 5'h00;
    for (int i = ivp_pkg::SRC_COUNT - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_any = 1'b1;
        o_idx = 5'(i);
      end
    end
  end
endmodule : ivp_prio_enc

// ==== tb/ivp_checker.sv ====
// checker: address and timing relations of the vector placement block
module ivp_checker (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_boot_reset_fuse,
  input wire logic        i_ctl_wr,
  input wire logic        i_irq_ready,
  input wire logic        i_global_irq_en,
  input wire logic        i_wr_vector_table_select,
  input wire logic        i_wr_vector_change_unlock,
  input wire logic [13:0] i_boot_addr,
  input wire logic [13:0] o_fetch_addr,
  input wire logic [19:0] i_irq_pending,
  input wire logic [19:0] i_irq_enable,
  input wire logic        o_reset_fetch,
  input wire logic        o_irq_take,
  input wire logic        o_vector_table_select,
  input wire logic        o_irq_blocked,
  input wire logic        o_vector_change_unlock,
  input wire logic [4:0]  o_vec_num
);
  default clocking dcb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  chk_reset_target: assert property ($fell(i_rst) |=> o_reset_fetch && o_vec_num == 5'h01 &&
    o_fetch_addr == (i_boot_reset_fuse ? 14'h0000 : i_boot_addr)) else $error("bad reset");
  chk_slot_addr: assert property (o_irq_take |-> o_fetch_addr ==
    (o_vector_table_select ? i_boot_addr : 14'h0000) + {8'h00, o_vec_num, 1'h0} - 14'h0002)
    else $error("bad slot");
  chk_take_cause: assert property (o_irq_take |-> $past(|(i_irq_pending & i_irq_enable)
    && i_global_irq_en && i_irq_ready)) else $error("take without cause");
  chk_lowest_wins: assert property (o_irq_take |-> o_vec_num > 5'h01 && ($past(i_irq_pending
    & i_irq_enable) & ((20'h1 << (o_vec_num - 5'h01)) - 20'h1)) == 20'h1 << (o_vec_num - 5'h02))
    else $error("wrong winner");
  chk_blocked_quiet: assert property (o_irq_blocked |-> !o_irq_take) else $error("take blocked");
  chk_unlock_quiet: assert property (i_ctl_wr && i_wr_vector_change_unlock |=>
    !o_irq_take) else $error("take in unlock cycle");
  chk_unlock_expire: assert property ($rose(o_vector_change_unlock) ##0 (!i_ctl_wr) [*4] |->
    o_vector_change_unlock ##1 !o_vector_change_unlock) else $error("bad unlock window");
  chk_select_write: assert property (o_vector_change_unlock && i_ctl_wr &&
    !i_wr_vector_change_unlock |=> !o_vector_change_unlock &&
    o_vector_table_select == $past(i_wr_vector_table_select)) else $error("select lost");
  chk_select_ignored: assert property (!o_vector_change_unlock && i_ctl_wr &&
    !i_wr_vector_change_unlock |=> $stable(o_vector_table_select)) else $error("select moved");
endmodule : ivp_checker
bind ivp_vector_place ivp_checker u_chk (.*);

// ==== tb/ivp_core_model.sv ====
// partner: core fetch side giving ready and instruction-done strobes
module ivp_core_model (
  input  wire logic i_ref_clk,
  input  wire logic i_slow,
  output logic      o_ready = 1'h1,
  output logic      o_done = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_q = 2'h0;
  always @(posedge i_ref_clk) begin
    cnt_q <= #1 cnt_q + 2'h1;
    o_ready <= #1 !i_slow || cnt_q[1];
    o_done <= #1 cnt_q[0];
  end
endmodule : ivp_core_model

// ==== tb/ivp_vector_place_tb.sv ====
// testbench: vector placement against expected slots
module ivp_vector_place_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("wrong value at %0t got %h exp %h", $time, a, e); end end
  localparam logic [13:0] BOOT = 14'h3800;
  logic        i_ref_clk = 0, i_rst = 1, i_boot_reset_fuse = 1, i_ctl_wr = 0, slow = 0;
  logic        ce = 1, gie = 1;
  logic        i_wr_vector_table_select = 0, i_wr_vector_change_unlock = 0;
  logic        i_irq_ready, i_instr_done, o_reset_fetch, o_irq_take, o_vector_table_select;
  logic        o_vector_change_unlock, o_irq_blocked;
  logic [19:0] i_irq_pending = 0, i_irq_enable = 0;
  logic [13:0] o_fetch_addr;
  logic [4:0]  o_vec_num;
  logic [18:0] exp_v, expq[$];
  int          mismatches = 0, tests_run = 0;
  ivp_vector_place uut (.*, .i_ce(ce), .i_global_irq_en(gie), .i_boot_addr(BOOT));
  ivp_core_model core (.i_ref_clk, .i_slow(slow), .o_ready(i_irq_ready), .o_done(i_instr_done));
  initial forever #20 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (o_irq_take || o_reset_fetch) begin
    exp_v = expq.size() ? expq.pop_front() : '1;
    `CHK({o_vec_num, o_fetch_addr}, exp_v)
  end
  task automatic ctl(input logic s, u, input logic [19:0] p);
    @(posedge i_ref_clk) #1;
    {i_ctl_wr, i_wr_vector_table_select, i_wr_vector_change_unlock} = {1'h1, s, u};
    i_irq_pending = p;
    @(posedge i_ref_clk) #1 {i_ctl_wr, i_irq_pending} = '0;
  endtask : ctl
  task automatic sweep(input logic [13:0] base);
    for (int b = 0; b < 20; b++) begin
      @(posedge i_ref_clk) #1;
      i_irq_pending = (20'($urandom) | (20'h1 << b)) & ~((20'h1 << b) - 20'h1);
      i_irq_enable = i_irq_pending | 20'($urandom);
      @(posedge i_ref_clk) if (i_irq_ready) expq.push_back({5'(b + 2), base + 14'(2 * b + 2)});
      #1 i_irq_pending = '0;
    end
  endtask : sweep
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    void'($urandom(32'h3714D2AE));
    expq.push_back({5'h01, 14'h0000});
    repeat (3) @(posedge i_ref_clk);
    #1 i_rst = 0;
    sweep(14'h0000);
    $display("test base table done");
    i_irq_enable = '1;
    @(posedge i_ref_clk) #1;
    {gie, i_irq_pending} = {1'h0, 20'h00001};
    repeat (2) @(posedge i_ref_clk) #1;
    `CHK(o_irq_take, 1'h0)
    {gie, ce} = 2'h2;
    repeat (2) @(posedge i_ref_clk) #1;
    `CHK(o_irq_take, 1'h0)
    {ce, i_irq_pending} = {1'h1, 20'h00000};
    $display("test masked done");
    ctl(1'h0, 1'h1, '0);
    ctl(1'h1, 1'h0, '1);
    `CHK(o_vector_table_select, 1'h1)
    repeat (2) @(posedge i_ref_clk) #1;
    for (int k = 0; k < 20 && o_irq_blocked; k++) @(posedge i_ref_clk) #1;
    if (o_irq_blocked !== 1'h0) begin
      mismatches++;
      tally_and_finish();
    end
    slow = 1;
    sweep(BOOT);
    $display("test boot table done");
    ctl(1'h0, 1'h1, '0);
    repeat (5) @(posedge i_ref_clk);
    ctl(1'h0, 1'h0, '0);
    `CHK(o_vector_table_select, 1'h1)
    $display("test late write done");
    @(posedge i_ref_clk) #1 {i_rst, i_boot_reset_fuse} = 2'h2;
    expq.push_back({5'h01, BOOT});
    @(posedge i_ref_clk) #1 i_rst = 0;
    repeat (3) @(posedge i_ref_clk) #1;
    `CHK(o_vector_table_select, 1'h0)
    `CHK(expq.size(), 0)
    $display("test boot reset done");
    tally_and_finish();
  end
endmodule : ivp_vector_place_tb
